// ### src/mdr_pkg.sv
// Shared constants and types for the multiplexed digit readout link
package mdr_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned NUM_DIGITS    = 4;
  localparam int unsigned NIBBLE_W      = 4;
  // Native scan period in microseconds; a slot is a quarter of it
  localparam int unsigned SCAN_US       = 1560;
  localparam int unsigned SCAN_CYC      = (CLK_HZ / 1_000_000) * SCAN_US;
  localparam int unsigned SLOT_CYC      = SCAN_CYC / NUM_DIGITS;
  // Short dark gap per slot; the strobe takes the rest, near 0.4 ms
  localparam int unsigned GAP_CYC       = 100;
  localparam int unsigned STROBE_CYC    = SLOT_CYC - GAP_CYC;
  localparam int unsigned CNT_W         = 14;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST    = CNT_W'(GAP_CYC - 1);
  // Counter ceiling and blink threshold, binary
  localparam logic [11:0] COUNT_MAX     = 12'hc1c;
  localparam logic [11:0] BLINK_AT      = 12'h7d0;
  localparam logic [11:0] COUNT_RESET   = 12'h000;
  localparam logic [3:0]  MSD_BIT_MASK  = 4'h3;
  localparam logic        TOGGLE_RESET  = 1'b0;

  // Native scan slots, gray along 1-3-2-4
  typedef enum logic [1:0] {
    MDR_SLOT_D1 = 2'b00,
    MDR_SLOT_D3 = 2'b01,
    MDR_SLOT_D2 = 2'b11,
    MDR_SLOT_D4 = 2'b10
  } mdr_slot_e;
endpackage : mdr_pkg

// ### src/mdr_link_if.sv
// Pins between the meter and the reordering logic
`timescale 1ns/1ps
interface mdr_link_if;
  logic [3:0] bcd;
  logic [3:0] digitStrobe;
  logic       transfer_n;

  modport meter  (output bcd, output digitStrobe, output transfer_n);
  modport reader (input bcd, input digitStrobe, input transfer_n);
endinterface : mdr_link_if

// ### src/mdr_meter.sv
// Meter end: counter and multiplexed BCD digit scan
//
// Overview of operation
// - Four digit positions, lsd first, msd partial
// - Native scan order is 1, 3, 2, 4
// - BCD and digit strobes drive active high
// - Transfer strobe is active low
// - Strobe about 0.4 ms, scan 1.56 ms
// - Reader toggle passes digits 1-2, then 3-4
// - Reader toggle advances on msd strobe fall
// - Reordered sequence spans two scans, 3.12 ms
// - Counter tops near 3100, blinks from 2000
// - Reader masks msd bits 4 and 8
`timescale 1ns/1ps
module mdr_meter (
  input  wire logic   ref_clk,
  input  wire logic   reset,
  input  wire logic   countPulse,
  mdr_link_if.meter   link,
  output logic        blinking,
  output logic [11:0] countValue
);
  typedef logic [mdr_pkg::CNT_W-1:0] mdr_cnt_t;

  // Scan sequencer
  mdr_pkg::mdr_slot_e slot;
  mdr_pkg::mdr_slot_e next_slot;
  mdr_cnt_t           timer;
  mdr_cnt_t           next_timer;
  logic               inStrobe;
  logic               next_inStrobe;
  logic               strobeDone;
  logic               gapDone;
  logic               scanEnd;
  logic [1:0]         slotIdx;

  // Count path
  logic [11:0]        count;
  logic [11:0]        latched;
  logic               atCeiling;

  // Registered pins
  logic [3:0]         bcd;
  logic [3:0]         strobe;
  logic               transfer_n;

  // Decimal digit of a binary count, position 0 the lsd
  function automatic logic [3:0] digitOf(input logic [11:0] value,
                                         input logic [1:0]  pos);
    logic [11:0] v;
    v = value;
    for (int i = 0; i < 3; i++) begin
      if (int'(pos) == i) begin
        return 4'(v % 12'd10);
      end
      v = v / 12'd10;
    end
    // Top position keeps the whole remaining quotient
    return 4'(v);
  endfunction : digitOf

  ////////////////////////////////////////////////////////////////////
  // Counter saturating at the ceiling
  assign atCeiling = (count >= mdr_pkg::COUNT_MAX);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= mdr_pkg::COUNT_RESET;
    end else if (countPulse && !atCeiling) begin
      count <= count + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slot order 1-3-2-4
  always_comb begin
    case (slot)
      mdr_pkg::MDR_SLOT_D1: next_slot = mdr_pkg::MDR_SLOT_D3;
      mdr_pkg::MDR_SLOT_D3: next_slot = mdr_pkg::MDR_SLOT_D2;
      mdr_pkg::MDR_SLOT_D2: next_slot = mdr_pkg::MDR_SLOT_D4;
      mdr_pkg::MDR_SLOT_D4: next_slot = mdr_pkg::MDR_SLOT_D1;
      default:              next_slot = mdr_pkg::MDR_SLOT_D1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Strobe then gap in each slot
  // Gap kept nonzero so the far end sees every strobe fall
  assign strobeDone = inStrobe && (timer == mdr_pkg::STROBE_LAST);
  assign gapDone    = !inStrobe && (timer == mdr_pkg::GAP_LAST);
  assign scanEnd    = gapDone && (slot == mdr_pkg::MDR_SLOT_D4);

  always_comb begin
    next_timer    = timer + 1'b1;
    next_inStrobe = inStrobe;
    if (strobeDone) begin
      next_timer    = '0;
      next_inStrobe = 1'b0;
    end else if (gapDone) begin
      next_timer    = '0;
      next_inStrobe = 1'b1;
    end
  end

  // Slot timer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer <= '0;
    end else begin
      timer <= next_timer;
    end
  end

  // Strobe phase; a scan opens with a strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      inStrobe <= 1'b1;
    end else begin
      inStrobe <= next_inStrobe;
    end
  end

  // Slot advances only as a gap ends
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot <= mdr_pkg::MDR_SLOT_D1;
    end else if (gapDone) begin
      slot <= next_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Latch count as a scan ends
  // Digits stay steady through a whole scan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latched <= mdr_pkg::COUNT_RESET;
    end else if (scanEnd) begin
      latched <= count;
    end
  end

  // One-cycle low transfer pulse beside the latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      transfer_n <= 1'b1;
    end else begin
      transfer_n <= !scanEnd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Digit position of the current slot
  function automatic int slot_pos(input mdr_pkg::mdr_slot_e s);
    case (s)
      mdr_pkg::MDR_SLOT_D1: return 0;
      mdr_pkg::MDR_SLOT_D2: return 1;
      mdr_pkg::MDR_SLOT_D3: return 2;
      default:              return 3;
    endcase
  endfunction : slot_pos

  assign slotIdx = 2'(slot_pos(slot));

  // Registered BCD nibble, active high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bcd <= 4'h0;
    end else begin
      bcd <= digitOf(latched, slotIdx);
    end
  end

  // Registered one-hot strobe, active high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strobe <= 4'h0;
    end else begin
      strobe <= inStrobe ? 4'(4'h1 << slotIdx) : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Overrange flag from the latched count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blinking <= 1'b0;
    end else begin
      blinking <= latched >= mdr_pkg::BLINK_AT;
    end
  end

  // Latched binary count for the host
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      countValue <= mdr_pkg::COUNT_RESET;
    end else begin
      countValue <= latched;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins onto the link
  assign link.bcd         = bcd;
  assign link.digitStrobe = strobe;
  assign link.transfer_n  = transfer_n;
endmodule : mdr_meter

// ### src/mdr_reader.sv
// Reader end: reorders 1-3-2-4 scan into 1-2-3-4
`timescale 1ns/1ps
module mdr_reader (
  input  wire logic  ref_clk,
  input  wire logic  reset,
  mdr_link_if.reader link,
  output logic [3:0] orderedStrobe,
  output logic [3:0] orderedBcd,
  output logic       digitValid,
  output logic [1:0] digitPos,
  output logic       transferSeen
);
  logic       pairHigh;
  logic       msdPrev;
  logic [3:0] gated;
  logic [3:0] nibble;

  ////////////////////////////////////////////////////////////////////
  // Toggle advances on falling edge of msd strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      msdPrev  <= 1'b0;
      pairHigh <= mdr_pkg::TOGGLE_RESET;
    end else begin
      msdPrev <= link.digitStrobe[3];
      if (msdPrev && !link.digitStrobe[3]) begin
        pairHigh <= !pairHigh;
      end
    end
  end

  // Pass digits 1-2 or 3-4 per scan
  always_comb begin
    gated = link.digitStrobe & (pairHigh ? 4'hc : 4'h3);
    nibble = link.bcd;
    if (link.digitStrobe[3]) begin
      nibble = link.bcd & mdr_pkg::MSD_BIT_MASK;
    end
  end

  function automatic logic [1:0] encodePos(input logic [3:0] oneHot);
    case (oneHot)
      4'h2:    return 2'h1;
      4'h4:    return 2'h2;
      4'h8:    return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : encodePos

  ////////////////////////////////////////////////////////////////////
  // Sample nibble while passed strobe is high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      orderedStrobe <= 4'h0;
      orderedBcd    <= 4'h0;
      digitValid    <= 1'b0;
      digitPos      <= 2'h0;
      transferSeen  <= 1'b0;
    end else begin
      orderedStrobe <= gated;
      digitValid    <= |gated;
      transferSeen  <= !link.transfer_n;
      if (|gated) begin
        orderedBcd <= nibble;
        digitPos   <= encodePos(gated);
      end
    end
  end
endmodule : mdr_reader

// ### testbench/mdr_link_props.sv
// Wire-level checks of the digit scan link
`timescale 1ns/1ps
module mdr_link_props (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [3:0] bcd,
  input wire logic [3:0] digitStrobe,
  input wire logic       transfer_n
);
  logic [3:0]  prev;
  logic [13:0] wid;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Last strobe seen; reset as if digit 4 just ended
  always_ff @(posedge ref_clk) begin
    if (reset)
      prev <= 4'h8;
    else if (|digitStrobe)
      prev <= digitStrobe;
  end
  always_ff @(posedge ref_clk) begin
    if (reset)
      wid <= 14'h0;
    else
      wid <= (|digitStrobe) ? wid + 14'h1 : 14'h0;
  end
  a_strobe_one_hot: assert property ($onehot0(digitStrobe))
    else $error("more than one digit strobe high");
  a_order_d1: assert property ($rose(digitStrobe[0]) |-> prev == 4'h8)
    else $error("digit 1 not after digit 4");
  a_order_d3: assert property ($rose(digitStrobe[2]) |-> prev == 4'h1)
    else $error("digit 3 not after digit 1");
  a_order_d2: assert property ($rose(digitStrobe[1]) |-> prev == 4'h4)
    else $error("digit 2 not after digit 3");
  a_order_d4: assert property ($rose(digitStrobe[3]) |-> prev == 4'h2)
    else $error("digit 4 not after digit 2");
  a_strobe_width: assert property (
    (digitStrobe == 4'h0 && wid != 14'h0) |-> wid == mdr_pkg::STROBE_CYC)
    else $error("digit strobe width wrong");
  a_transfer_pulse: assert property ($fell(transfer_n) |=> transfer_n)
    else $error("transfer low longer than one cycle");
  a_transfer_after_msd: assert property (
    !transfer_n |-> prev == 4'h8 && digitStrobe == 4'h0)
    else $error("transfer outside msd gap");
  a_msd_range: assert property (digitStrobe[3] |-> bcd <= 4'h3)
    else $error("msd nibble above three");
  c_transfer: cover property ($fell(transfer_n));
  c_msd: cover property ($rose(digitStrobe[3]));
  c_width: cover property (digitStrobe == 4'h0 && wid != 14'h0);
endmodule : mdr_link_props

// ### testbench/tb_multiplexed_digit_readout_reorder.sv
// Self-checking bench joining meter and reorder ends
`timescale 1ns/1ps
module tb_multiplexed_digit_readout_reorder;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        countPulse = 1'b0;
  logic [3:0]  orderedStrobe, orderedBcd;
  logic [1:0]  digitPos;
  logic        digitValid, transferSeen, blinking;
  logic [11:0] countValue;
  int          failures = 0, checked = 0, cycles = 0, xferAt = 0;
  mdr_link_if link ();
  mdr_meter i_mdr_meter (.ref_clk(ref_clk), .reset(reset),
    .countPulse(countPulse), .link(link), .blinking(blinking),
    .countValue(countValue));
  mdr_reader i_mdr_reader (.ref_clk(ref_clk), .reset(reset), .link(link),
    .orderedStrobe(orderedStrobe), .orderedBcd(orderedBcd),
    .digitValid(digitValid), .digitPos(digitPos),
    .transferSeen(transferSeen));
  mdr_link_props i_mdr_link_props (.ref_clk(ref_clk), .reset(reset),
    .bcd(link.bcd), .digitStrobe(link.digitStrobe),
    .transfer_n(link.transfer_n));
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic compare(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic compare_cycles(input logic [31:0] got,
                                input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_cycles
  // Two scans plus margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // More pulses than the ceiling; extra ones must be dropped
  task automatic count_to_ceiling();
    countPulse = 1'b1;
    repeat (3200) @(negedge ref_clk);
    countPulse = 1'b0;
  endtask : count_to_ceiling
  task automatic check_slot(input int idx, input logic pass,
                            input logic [3:0] expBcd);
    int n;
    n = 0;
    while (link.digitStrobe === 4'h0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    compare(12'(link.digitStrobe), 12'(4'h1 << idx));
    compare(12'(link.bcd), 12'(expBcd));
    repeat (2) @(negedge ref_clk);
    compare(12'(orderedStrobe), pass ? 12'(4'h1 << idx) : 12'h0);
    compare(12'(digitValid), 12'(pass));
    if (pass) begin
      compare(12'(orderedBcd), 12'(expBcd));
      compare(12'(digitPos), 12'(idx));
    end
    while (link.digitStrobe !== 4'h0)
      @(negedge ref_clk);
  endtask : check_slot
  // First scan after reset passes digits 1 and 2 of a zero latch
  task automatic scan_first();
    compare(countValue, 12'h000);
    compare(12'(blinking), 12'h0);
    check_slot(0, 1'b1, 4'h0);
    check_slot(2, 1'b0, 4'h0);
    check_slot(1, 1'b1, 4'h0);
    check_slot(3, 1'b0, 4'h0);
  endtask : scan_first
  // Following scan passes digits 3 and 4 of the latched 3100
  task automatic scan_second();
    check_slot(0, 1'b0, 4'h0);
    check_slot(2, 1'b1, 4'h1);
    check_slot(1, 1'b0, 4'h0);
    check_slot(3, 1'b1, 4'h3);
  endtask : scan_second
  // Next transfer comes one native scan later
  task automatic scan_period();
    int n;
    n = 0;
    while (link.transfer_n !== 1'b0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    compare_cycles(cycles - xferAt, mdr_pkg::SCAN_CYC);
  endtask : scan_period
  task automatic transfer_latch();
    int n;
    n = 0;
    while (link.transfer_n !== 1'b0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    xferAt = cycles;
    compare(12'(link.transfer_n), 12'h0);
    @(negedge ref_clk);
    compare(12'(link.transfer_n), 12'h1);
    compare(12'(transferSeen), 12'h1);
    repeat (2) @(negedge ref_clk);
    compare(countValue, 12'hc1c);
    compare(12'(blinking), 12'h1);
  endtask : transfer_latch
  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    count_to_ceiling();
    scan_first();
    transfer_latch();
    scan_second();
    scan_period();
    report_and_stop();
  end
endmodule : tb_multiplexed_digit_readout_reorder
